// ===== logic/gpt_timers.sv
// Timer group: 16-bit main timer with five compare/capture channels,
// two 8-bit timers and the infrared modulation output.
// Assumes all inputs synchronous to core_clk; no register bus.
`timescale 1ns/1ps
`include "gpt_params.svh"

module gpt_timers (
  input wire core_clk,
  input wire sys_rst,
  input wire main_en,
  input gpt_pkg::gpt_src_e main_src,
  input wire [`GPT_PSEL_W-1:0] main_psel,
  input wire [`GPT_MAIN_W-1:0] main_period,
  input wire [`GPT_NUM_CH-1:0] ch_capture,
  input wire [`GPT_NUM_CH*`GPT_EDGE_W-1:0] ch_edge,
  input wire [`GPT_NUM_CH*`GPT_MAIN_W-1:0] ch_cmp,
  input wire [`GPT_NUM_CH-1:0] cap_in,
  input wire main_count_in,
  input wire sa_en,
  input wire sa_count_mode,
  input wire [`GPT_PSEL_W-1:0] sa_psel,
  input wire [`GPT_SMALL_W-1:0] sa_period,
  input wire [`GPT_SMALL_W-1:0] sa_cmp,
  input wire sa_count_in,
  input wire sb_en,
  input wire sb_count_mode,
  input wire [`GPT_PSEL_W-1:0] sb_psel,
  input wire [`GPT_SMALL_W-1:0] sb_period,
  input wire [`GPT_SMALL_W-1:0] sb_cmp,
  input wire sb_count_in,
  output logic [`GPT_MAIN_W-1:0] main_cnt_q,
  output logic main_wrap_q,
  output logic [`GPT_NUM_CH-1:0] ch_pwm_q,
  output logic [`GPT_NUM_CH*`GPT_MAIN_W-1:0] cap_val_q,
  output logic [`GPT_NUM_CH-1:0] cap_evt_q,
  output logic ir_out_q,
  output logic [`GPT_SMALL_W-1:0] sa_cnt_q,
  output logic sa_pwm_q,
  output logic [`GPT_SMALL_W-1:0] sb_cnt_q,
  output logic sb_pwm_q
);

  logic [`GPT_PRESC_W-1:0] presc_q; // Main prescaler count
  logic [`GPT_PRESC_W-1:0] mask; // Divide mask from psel
  logic presc_tick; // Prescaled clock event
  logic cin_prev_q; // Previous external count level
  logic sa_wrap; // First small timer completed a period
  logic tick; // Main counter advance event
  logic at_period; // Main counter sits on its period
  logic ir_mode; // Infrared generation selected
  logic [`GPT_NUM_CH-1:0] cap_prev_q; // Capture input history
  logic [`GPT_NUM_CH-1:0] cap_hit; // Selected edge seen

  // First small timer, also the IR carrier and count source
  gpt_small_timer u_small_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tmr_en(sa_en),
    .count_mode(sa_count_mode),
    .psel(sa_psel),
    .period(sa_period),
    .cmp_val(sa_cmp),
    .count_in(sa_count_in),
    .cnt_q(sa_cnt_q),
    .pwm_q(sa_pwm_q),
    .wrap_q(sa_wrap)
  );

  // Second small timer, stand-alone
  gpt_small_timer u_small_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tmr_en(sb_en),
    .count_mode(sb_count_mode),
    .psel(sb_psel),
    .period(sb_period),
    .cmp_val(sb_cmp),
    .count_in(sb_count_in),
    .cnt_q(sb_cnt_q),
    .pwm_q(sb_pwm_q),
    .wrap_q()
  );

  assign ir_mode = (main_src == gpt_pkg::GPT_SRC_IR);
  assign mask = `GPT_PRESC_W'((8'h01 << main_psel) - 8'h01);
  assign presc_tick = main_en && ((presc_q & mask) == mask);
  assign at_period = (main_cnt_q == main_period);

  // Main advance source; IR mode steps once per carrier period
  always_comb begin
    tick = 1'b0;
    case (main_src)
      // Prescaled core clock
      gpt_pkg::GPT_SRC_TIMER: tick = presc_tick;
      // Rising edges on the external count input
      gpt_pkg::GPT_SRC_COUNTER: tick = main_en && main_count_in
                                       && !cin_prev_q;
      // Completed periods of the first small timer
      gpt_pkg::GPT_SRC_IR: tick = main_en && sa_wrap;
      // Unused code stops the counter
      default: tick = 1'b0;
    endcase
  end

  // Main prescaler, restarted while disabled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q <= `GPT_PRESC_RST;
    end else if (!main_en || presc_tick) begin
      presc_q <= `GPT_PRESC_RST;
    end else begin
      presc_q <= presc_q + `GPT_PRESC_W'(1);
    end
  end

  // External count input history
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cin_prev_q <= 1'b0;
    end else begin
      cin_prev_q <= main_count_in;
    end
  end

  // Main up counter, wraps to zero after period
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_cnt_q <= `GPT_MAIN_RST;
      main_wrap_q <= 1'b0;
    end else begin
      main_wrap_q <= tick && at_period;
      if (tick) begin
        main_cnt_q <= at_period ? `GPT_MAIN_RST
                                : main_cnt_q + `GPT_MAIN_W'(1);
      end
    end
  end

  // Capture input history, one bit per channel
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_prev_q <= '0;
    end else begin
      cap_prev_q <= cap_in;
    end
  end

  // Per-channel compare and capture logic
  genvar i;
  generate
    for (i = 0; i < `GPT_NUM_CH; i++) begin : g_ch
      logic [`GPT_MAIN_W-1:0] cmp; // This channel's compare value

      assign cmp = ch_cmp[i*`GPT_MAIN_W +: `GPT_MAIN_W];
      // Edge filter by the channel's edge select
      assign cap_hit[i] =
        (ch_edge[i*`GPT_EDGE_W + `GPT_EDGE_RISE] && cap_in[i]
         && !cap_prev_q[i]) ||
        (ch_edge[i*`GPT_EDGE_W + `GPT_EDGE_FALL] && !cap_in[i]
         && cap_prev_q[i]);

      // PWM: set on match, restore at wrap; held low in capture
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ch_pwm_q[i] <= 1'b0;
        end else if (ch_capture[i]) begin
          ch_pwm_q[i] <= 1'b0;
        end else if (tick) begin
          if (at_period) begin
            ch_pwm_q[i] <= 1'b0;
          end else if ((main_cnt_q + `GPT_MAIN_W'(1)) == cmp) begin
            ch_pwm_q[i] <= 1'b1;
          end
        end
      end

      // Capture: freeze the count that stood when the edge arrived
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cap_val_q[i*`GPT_MAIN_W +: `GPT_MAIN_W] <= `GPT_MAIN_RST;
          cap_evt_q[i] <= 1'b0;
        end else begin
          cap_evt_q[i] <= ch_capture[i] && cap_hit[i];
          if (ch_capture[i] && cap_hit[i]) begin
            cap_val_q[i*`GPT_MAIN_W +: `GPT_MAIN_W] <= main_cnt_q;
          end
        end
      end

      chk_ch_set: assert property (@(posedge core_clk)
        disable iff (sys_rst) $rose(ch_pwm_q[i]) |-> main_cnt_q == cmp)
        else $error("channel output rose away from compare");

      chk_ch_restore: assert property (@(posedge core_clk)
        disable iff (sys_rst) main_wrap_q |-> !ch_pwm_q[i])
        else $error("channel output not restored at wrap");

      chk_cap_value: assert property (@(posedge core_clk)
        disable iff (sys_rst) ch_capture[i] && cap_hit[i] |=>
        cap_evt_q[i] && cap_val_q[i*`GPT_MAIN_W +: `GPT_MAIN_W] ==
        $past(main_cnt_q))
        else $error("capture did not hold the edge count");
    end
  endgenerate

  // IR output: main channel zero gated by the carrier
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_out_q <= 1'b0;
    end else begin
      ir_out_q <= ir_mode && ch_pwm_q[0] && sa_pwm_q;
    end
  end

  chk_main_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && at_period |=> main_cnt_q == `GPT_MAIN_RST && main_wrap_q)
    else $error("main timer did not wrap at period");

  chk_main_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && !at_period |=> main_cnt_q == $past(main_cnt_q) + 16'h0001)
    else $error("main timer did not advance on tick");

  chk_ir_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    main_en && ir_mode && !sa_wrap |=> $stable(main_cnt_q))
    else $error("IR mode advanced without a carrier period");

  chk_ir_and: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 ir_out_q == $past(ir_mode && ch_pwm_q[0] && sa_pwm_q))
    else $error("IR output is not the AND of both outputs");

endmodule

// ===== logic/gpt_params.svh
// Constants shared by the general purpose timer group.
// Assumes inclusion by bare name from the logic/ folder.
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH

// Counter widths
`define GPT_MAIN_W 16
`define GPT_SMALL_W 8
// Number of compare/capture channels on the main timer
`define GPT_NUM_CH 5
// Prescaler counter width and divider select width
`define GPT_PRESC_W 7
`define GPT_PSEL_W 3
// Edge select field: bit 0 rising, bit 1 falling
`define GPT_EDGE_W 2
`define GPT_EDGE_RISE 0
`define GPT_EDGE_FALL 1
// Reset values
`define GPT_MAIN_RST 16'h0000
`define GPT_SMALL_RST 8'h00
`define GPT_PRESC_RST 7'h00

`endif

// ===== logic/gpt_pkg.sv
// Types shared by the general purpose timer group.
// Assumes nothing beyond a SystemVerilog compiler.
package gpt_pkg;

  // Count source of the main timer
  typedef enum logic [1:0] {
    GPT_SRC_TIMER,
    GPT_SRC_COUNTER,
    GPT_SRC_IR
  } gpt_src_e;

endpackage

// ===== logic/gpt_small_timer.sv
// One 8-bit timer: prescaler, period, one compare channel with PWM out.
// Assumes inputs synchronous to core_clk.
`timescale 1ns/1ps
`include "gpt_params.svh"

module gpt_small_timer (
  input wire core_clk,
  input wire sys_rst,
  input wire tmr_en,
  input wire count_mode,
  input wire [`GPT_PSEL_W-1:0] psel,
  input wire [`GPT_SMALL_W-1:0] period,
  input wire [`GPT_SMALL_W-1:0] cmp_val,
  input wire count_in,
  output logic [`GPT_SMALL_W-1:0] cnt_q,
  output logic pwm_q,
  output logic wrap_q
);

  logic [`GPT_PRESC_W-1:0] presc_q; // Prescaler count
  logic [`GPT_PRESC_W-1:0] mask; // Divide mask from psel
  logic presc_tick; // Prescaled clock event
  logic cin_prev_q; // Previous count input level
  logic tick; // Counter advance event
  logic at_period; // Counter sits on its period

  // Divide by two to the power psel
  assign mask = `GPT_PRESC_W'((8'h01 << psel) - 8'h01);
  assign presc_tick = tmr_en && ((presc_q & mask) == mask);
  // Counter mode counts rising edges of the input instead
  assign tick = tmr_en && (count_mode ? (count_in && !cin_prev_q)
                                      : presc_tick);
  assign at_period = (cnt_q == period);

  // Prescaler, restarted while disabled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q <= `GPT_PRESC_RST;
    end else if (!tmr_en || presc_tick) begin
      presc_q <= `GPT_PRESC_RST;
    end else begin
      presc_q <= presc_q + `GPT_PRESC_W'(1);
    end
  end

  // Edge history of the count input
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cin_prev_q <= 1'b0;
    end else begin
      cin_prev_q <= count_in;
    end
  end

  // Up counter, wraps to zero after period
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= `GPT_SMALL_RST;
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= tick && at_period;
      if (tick) begin
        cnt_q <= at_period ? `GPT_SMALL_RST : cnt_q + `GPT_SMALL_W'(1);
      end
    end
  end

  // PWM: set on compare, restored at wrap
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_q <= 1'b0;
    end else if (tick) begin
      if (at_period) begin
        pwm_q <= 1'b0;
      end else if ((cnt_q + `GPT_SMALL_W'(1)) == cmp_val) begin
        pwm_q <= 1'b1;
      end
    end
  end

  chk_small_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && at_period |=> cnt_q == `GPT_SMALL_RST && wrap_q)
    else $error("small timer did not wrap at period");

  chk_small_pwm_set: assert property (@(posedge core_clk)
    disable iff (sys_rst) $rose(pwm_q) |-> cnt_q == cmp_val)
    else $error("small timer pwm rose away from compare");

  chk_small_restore: assert property (@(posedge core_clk)
    disable iff (sys_rst) wrap_q |-> !pwm_q)
    else $error("small timer pwm not restored at wrap");

endmodule

// ===== testbench/gpt_pin_model.sv
// Pin-side model: capture pads and the external count input.
// Assumes requests change at core_clk rising edges.
`timescale 1ns/1ps

module gpt_pin_model (
  input wire core_clk,
  input wire [5:0] pin_req,
  output logic [4:0] cap_in = 5'h00,
  output logic main_count_in = 1'b0
);
  // Pads follow a request one clock late, like a slow outside source
  always @(posedge core_clk) begin
    cap_in <= pin_req[4:0];
    main_count_in <= pin_req[5];
  end
endmodule

// ===== testbench/general_purpose_timer_pwm_ir_tb_top.sv
// Self-checking bench for the timer group, stimulus by clock-edge calls.
// Assumes gpt_timers and gpt_pin_model are compiled before it.
`timescale 1ns/1ps

module general_purpose_timer_pwm_ir_tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic main_en, sa_en, sb_en;
  gpt_pkg::gpt_src_e main_src;
  logic [2:0] main_psel, sb_psel;
  logic [15:0] main_period;
  logic [7:0] sa_period, sa_cmp, sb_period, sb_cmp;
  logic [4:0] ch_capture, cap_in, ch_pwm_q, cap_evt_q, seen;
  logic [9:0] ch_edge;
  logic [79:0] ch_cmp, cap_val_q;
  logic [5:0] pin_req;
  logic main_count_in, main_wrap_q, ir_out_q, sa_pwm_q, sb_pwm_q;
  logic [15:0] main_cnt_q;
  logic [7:0] sa_cnt_q, sb_cnt_q;
  logic sb_count_mode = 1'b0;
  logic sb_count_in = 1'b0;
  int error_cnt = 0;
  int check_count = 0;

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // First small timer stays on the prescaled clock source
  gpt_timers i_dut (.core_clk, .sys_rst, .main_en, .main_src, .main_psel,
    .main_period, .ch_capture, .ch_edge, .ch_cmp, .cap_in, .main_count_in,
    .sa_en, .sa_count_mode(1'b0), .sa_psel(3'h0), .sa_period, .sa_cmp,
    .sa_count_in(1'b0), .sb_en, .sb_count_mode, .sb_psel, .sb_period,
    .sb_cmp, .sb_count_in, .main_cnt_q, .main_wrap_q, .ch_pwm_q,
    .cap_val_q, .cap_evt_q, .ir_out_q, .sa_cnt_q, .sa_pwm_q, .sb_cnt_q,
    .sb_pwm_q);

  gpt_pin_model i_pins (.core_clk, .pin_req, .cap_in, .main_count_in);

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: 0x%0h vs 0x%0h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Drive all capture pads, gather event pulses over a few cycles
  task automatic cap_step(input logic lvl, input logic [4:0] exp);
    @(posedge core_clk);
    pin_req[4:0] <= {5{lvl}};
    seen = 5'h00;
    repeat (4) begin
      @(posedge core_clk);
      #1 seen = seen | cap_evt_q;
      chk(ch_pwm_q, 16'h0000);
    end
    chk(seen, exp);
  endtask

  // Cut a hang short; the whole run needs about a hundred cycles
  initial begin
    #40000;
    error_cnt++;
    summarize;
  end

  initial begin
    {main_en, sa_en, sb_en} = 3'h0;
    main_src = gpt_pkg::GPT_SRC_TIMER;
    {main_psel, sb_psel} = {3'h0, 3'h1};
    main_period = 16'h0009;
    {sa_period, sa_cmp, sb_period, sb_cmp} = 32'h0201_0403;
    {ch_capture, ch_edge, pin_req} = 21'h000000;
    // Zero cmp and cmp above period both keep the output low
    ch_cmp = {16'h000C, 16'h0009, 16'h0005, 16'h0003, 16'h0000};
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk(main_cnt_q, 16'h0000);
    chk(ch_pwm_q, 16'h0000);
    chk(ir_out_q, 16'h0000);
    chk(sa_cnt_q, 16'h0000);
    chk(sb_cnt_q, 16'h0000);
    @(posedge core_clk);
    {main_en, sa_en, sb_en} <= 3'h7;
    // All three timers run side by side; main stops after cycle 23
    for (int k = 1; k <= 23; k++) begin
      @(posedge core_clk);
      if (k == 23)
        main_en <= 1'b0;
      #1 chk(sa_cnt_q, 16'(k % 3));
      chk(sa_pwm_q, 16'(k % 3 != 0));
      chk(main_cnt_q, 16'(k % 10));
      chk(main_wrap_q, 16'(k % 10 == 0));
      for (int i = 0; i < 5; i++)
        chk(ch_pwm_q[i], 16'(ch_cmp[16*i+:16] != 0
          && k % 10 >= ch_cmp[16*i+:16]));
      if (k % 2 == 0) begin
        chk(sb_cnt_q, 16'((k / 2) % 5));
        chk(sb_pwm_q, 16'((k / 2) % 5 >= 3));
      end
    end
    // Capture on a frozen count: ch0 rise, ch1 fall, ch2 both...
    @(posedge core_clk);
    ch_capture <= 5'h1F;
    ch_edge <= 10'h279;
    cap_step(1'b1, 5'h0D);
    cap_step(1'b0, 5'h16);
    for (int i = 0; i < 5; i++)
      chk(cap_val_q[16*i+:16], 16'h0003);
    // External count source: four pulses on top of the held 3
    @(posedge core_clk);
    main_src <= gpt_pkg::GPT_SRC_COUNTER;
    main_en <= 1'b1;
    repeat (4) begin
      @(posedge core_clk);
      pin_req[5] <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk);
      pin_req[5] <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    #1 chk(main_cnt_q, 16'h0007);
    // Prescaled clock, divide by four: one step every fourth edge
    @(posedge core_clk);
    main_src <= gpt_pkg::GPT_SRC_TIMER;
    main_psel <= 3'h2;
    repeat (3) @(posedge core_clk);
    #1 chk(main_cnt_q, 16'h0007);
    @(posedge core_clk);
    #1 chk(main_cnt_q, 16'h0008);
    repeat (3) @(posedge core_clk);
    #1 chk(main_cnt_q, 16'h0008);
    @(posedge core_clk);
    #1 chk(main_cnt_q, 16'h0009);
    // Mid-run reset, then infrared mode from a clean start
    @(posedge core_clk);
    sys_rst <= 1'b1;
    {main_en, sa_en, sb_en, ch_capture} <= 8'h00;
    main_src <= gpt_pkg::GPT_SRC_IR;
    main_period <= 16'h0063;
    ch_cmp <= 80'h2;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    {main_en, sa_en, sb_en} <= 3'h7;
    sb_count_mode <= 1'b1;
    // Main steps once per small timer wrap, output is the AND;
    // second small timer counts pulses on its own input meanwhile
    for (int k = 1; k <= 15; k++) begin
      @(posedge core_clk);
      sb_count_in <= (k % 3 == 0);
      #1 chk(main_cnt_q, 16'((k - 1) / 3));
      chk(sb_cnt_q, 16'((k - 1) / 3));
      chk(sb_pwm_q, 16'((k - 1) / 3 >= 3));
      chk(ir_out_q, 16'(k >= 8 && (k - 1) % 3 != 0));
    end
    summarize;
  end
endmodule
